//--- dv/glm_load_relax_tb_top.sv
// Purpose: self-checking bench for load model selection and rest detection
// Assumes: tick shortened to 20 clocks, bench drives all ports itself
// Notes: expectations come from the written config, never from the outputs
`timescale 1ns/1ps
module glm_load_relax_tb_top;
  logic clk = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
  logic [4:0] regAddr = 5'h00;
  logic [15:0] regWdata = 16'h0000, regRdata, remainingCharge = 16'h0010;
  logic [15:0] remainingEnergy = 16'h0010;
  glm_pkg::glm_meas_t meas = '0; // all measurements quiet at start
  glm_pkg::glm_out_t status;
  int errors = 0, comparisons = 0, i;
  // ------------------------------
  // clock, device, watchdog
  // ------------------------------
  always #5 clk = ~clk;
  glm_load_relax #(.TICK_CYCLES(20)) dut_u (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .meas(meas), .remainingCharge(remainingCharge), .remainingEnergy(remainingEnergy),
    .status(status));
  // cut a hang well past the longest wait (ocv needs 360 ticks)
  initial begin
    #200_000;
    errors++;
    give_verdict();
  end
  // ------------------------------
  // tasks
  // ------------------------------
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk("regRdata", exp, regRdata);
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic model(input logic [15:0] c, input logic [15:0] exp);
    wr(glm_pkg::REG_CTRL, c);
    settle(2);
    chk("loadModel", exp, status.loadModel);
    chk("loadModeStatus", {15'h0000, c[0]}, {15'h0000, status.loadModeStatus});
    chk("compRate", c[8] ? exp : 16'h0000, status.compRate);
    chk("resCompLoaded", {15'h0000, c[8]}, {15'h0000, status.resCompLoaded});
  endtask : model
  task automatic give_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(glm_pkg::REG_CTRL, 16'h0010);
    rd(5'h1F, 16'h0000);
    wr(glm_pkg::REG_DCAP, 16'h01F4);
    wr(glm_pkg::REG_DENERGY, 16'h03E8);
    wr(glm_pkg::REG_HRATE, 16'h0123);
    wr(glm_pkg::REG_URATE_I, 16'h0045);
    wr(glm_pkg::REG_URATE_P, 16'h0067);
    wr(glm_pkg::REG_QMAX, 16'h0100);
    rd(glm_pkg::REG_QMAX, 16'h0100);
    model(16'h0040, 16'h0064);
    model(16'h0150, 16'h0123);
    model(16'h0060, 16'h0045);
    model(16'h0141, 16'h00C8);
    model(16'h0051, 16'h0123);
    model(16'h0161, 16'h0067);
    @(posedge clk);
    meas.avgCurrent <= -16'sd1000;
    meas.voltage <= 16'd10000;
    model(16'h0020, 16'h03E8);
    model(16'h0021, 16'h2710);
    wr(glm_pkg::REG_ESCALE, 16'h0005);
    rd(glm_pkg::REG_ESCALE, 16'h0001);
    wr(glm_pkg::REG_ESCALE, 16'h000A);
    model(16'h0021, 16'h03E8);
    wr(glm_pkg::REG_RES_EN, 16'h0044);
    wr(glm_pkg::REG_RES_CHG, 16'h0033);
    remainingCharge <= 16'h0000;
    settle(3);
    chk("resChgInUse", 16'h0001, {15'h0000, status.resChgInUse});
    chk("resEnInUse", 16'h0000, {15'h0000, status.resEnInUse});
    chk("resChg", 16'h0033, status.resChg);
    chk("resEn", 16'h0044, status.resEn);
    @(posedge clk);
    meas.current <= -16'sd100;
    settle(3);
    chk("dsgFlow edge", 16'h0000, {15'h0000, status.dischargeFlow});
    @(posedge clk);
    meas.current <= -16'sd101;
    // twenty edges always hold one tick, so the cycle has its first sample
    settle(20);
    chk("dsgFlow", 16'h0001, {15'h0000, status.dischargeFlow});
    model(16'h0010, 16'h0065);
    model(16'h0011, 16'h0065);
    model(16'h0001, 16'h0000);
    @(posedge clk);
    meas.current <= 16'sd101;
    // a tick with charge flowing closes the cycle into the last-run values
    settle(20);
    chk("chgFlow", 16'h0001, {15'h0000, status.chargeFlow});
    model(16'h0000, 16'h0065);
    model(16'h0001, 16'h0065);
    model(16'h0071, 16'h0065);
    // quiet, charge was last flow so the charge relax time applies
    wr(glm_pkg::REG_CHG_RLX, 16'h0002);
    meas.current <= 16'sd0;
    meas.avgCurrent <= 16'sd0;
    for (i = 0; i < 200 && status.relaxActive !== 1'b1; i++) settle(1);
    chk("relaxActive", 16'h0001, {15'h0000, status.relaxActive});
    chk("ocv early", 16'h0000, {15'h0000, status.ocvEnable});
    for (i = 0; i < 8000 && status.qmaxUpdateEnable !== 1'b1; i++) settle(1);
    chk("ocvEnable", 16'h0001, {15'h0000, status.ocvEnable});
    chk("qmaxUpd", 16'h0001, {15'h0000, status.qmaxUpdateEnable});
    @(posedge clk);
    meas.qmaxSample <= 16'h0ABC;
    meas.qmaxValid <= 1'b1;
    @(posedge clk);
    meas.qmaxValid <= 1'b0;
    rd(glm_pkg::REG_QMAX, 16'h0ABC);
    @(posedge clk);
    meas.dvdt <= 16'h0004;
    settle(3);
    chk("qmaxUpd dvdt", 16'h0000, {15'h0000, status.qmaxUpdateEnable});
    @(posedge clk);
    meas.avgCurrent <= -16'sd500;
    for (i = 0; i < 100 && status.relaxActive !== 1'b0; i++) settle(1);
    chk("relax exit", 16'h0000, {15'h0000, status.relaxActive});
    give_verdict();
  end
endmodule : glm_load_relax_tb_top

//--- logic/glm_load_relax.sv
// Purpose: load model selection, reserve compensation and rest detection
// Assumes: measurements synchronous to clk, one-second internal tick
// Notes: all state is one struct registered every edge
// How it works
// R1: current mode sel 0: last-run average current
// R2: current mode sel 1: present-cycle average current
// R3: sel 2 average current, 3 filtered
// R4: current mode sel 4: design capacity over five
// R5: sel 5 host rate, 6 user current
// R6: power mode sel 0: last-run average power
// R7: power mode sel 1: present-cycle average power
// R8: sel 2/3: current times voltage
// R9: power mode sel 4: design energy over five
// R10: sel 5 host rate, 6 user power
// R11: hold reserve once remaining reaches zero
// R12: reserve select picks loaded or no-load
// R13: software writes energy scale 1 or 10
// R14: scale ten makes power centiwatt units
// R15: discharge flow above discharge threshold
// R16: charge flow above charge threshold
// R17: quiet for relax time enters rest
// R18: six minutes resting enables voltage readings
// R19: capacity update needs dV/dt below four
// R20: leave rest after quit relax time
// R21: max capacity updated, seeded by software
// R22: status bit mirrors load mode
// R23: selector above six acts as default
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
module glm_load_relax #(
  parameter int TICK_CYCLES = glm_pkg::TICK_CYCLES // shorten in simulation
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdata,
  input wire glm_pkg::glm_meas_t meas,
  input wire logic [15:0] remainingCharge,
  input wire logic [15:0] remainingEnergy,
  output glm_pkg::glm_out_t status
);
  // ---------------------------------------------
  // state
  // ---------------------------------------------
  typedef struct packed {
    glm_pkg::glm_cfg_t cfg; // software settings
    glm_pkg::glm_relax_t relax; // flowing or resting
    logic lastChg; // last flow direction was charge
    logic inCycle; // discharge cycle open
    logic [31:0] tickCnt; // second divider
    logic [15:0] dwell; // seconds spent meeting a criterion
    logic [15:0] relaxSecs; // seconds in rest
    logic [31:0] sumI, sumP; // present-cycle sums
    logic [15:0] cnt; // present-cycle samples
    logic [15:0] lastI, lastP; // last-run averages
    logic signed [15:0] filt; // low-pass current
    logic [15:0] qmax; // chemical capacity
    logic [15:0] rdata; // read data stage
    glm_pkg::glm_out_t out; // registered outputs
  } glm_state_t;
  glm_state_t s; // present state
  glm_state_t next_s; // next state
  localparam logic signed [16:0] TauDiv = 17'(glm_pkg::LPF_TAU_S);
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  // magnitude of a signed value, most negative clipped
  function automatic logic [15:0] magnitude(input logic signed [15:0] v);
    logic [15:0] r;
    r = v[15] ? 16'(-v) : 16'(v);
    if (v == 16'sh8000) r = 16'h7FFF;
    return r;
  endfunction : magnitude
  // clip a wide value to 16 bits
  function automatic logic [15:0] sat16(input logic [31:0] v);
    return (v > 32'h0000_FFFF) ? 16'hFFFF : v[15:0];
  endfunction : sat16
  // saturating seconds counter
  function automatic logic [15:0] incSat(input logic [15:0] v);
    return (v == 16'hFFFF) ? v : 16'(v + 16'h0001);
  endfunction : incSat
  // running average, zero before the first sample
  function automatic logic [15:0] avgOf(input logic [31:0] sum, input logic [15:0] n);
    return (n == 16'h0000) ? 16'h0000 : sat16(sum / {16'h0000, n});
  endfunction : avgOf
  // current times voltage in the unit the energy scale selects
  function automatic logic [15:0] power(input logic [15:0] i, input logic [15:0] v,
                                        input logic [15:0] esc);
    logic [31:0] p;
    p = {16'h0000, i} * {16'h0000, v};
    return sat16(p / ((esc == glm_pkg::ESCALE_TEN) ? glm_pkg::PWR_DIV_CENTI
                                                  : glm_pkg::PWR_DIV_MILLI)); // R14
  endfunction : power
  // ---------------------------------------------
  // next state
  // ---------------------------------------------
  always_comb begin
    logic tick;
    logic dsgNow, chgNow, quiet, loud, closeCycle;
    logic [15:0] magI, magAvg, magFilt, presI, presP, instP, dwellLim, model;
    logic signed [16:0] diff;
    tick = 1'b0;
    dsgNow = 1'b0;
    chgNow = 1'b0;
    quiet = 1'b0;
    loud = 1'b0;
    closeCycle = 1'b0;
    magI = magnitude(meas.current);
    magAvg = magnitude(meas.avgCurrent);
    magFilt = magnitude(s.filt);
    presI = avgOf(s.sumI, s.cnt);
    presP = avgOf(s.sumP, s.cnt);
    instP = power(magI, meas.voltage, s.cfg.escale);
    dwellLim = s.lastChg ? s.cfg.chgRlx : s.cfg.dsgRlx;
    model = 16'h0000;
    diff = 17'sh0_0000;
    next_s = s;
    next_s.rdata = 16'h0000;
    // one-second tick paces averaging and dwell timing
    tick = (s.tickCnt == 32'(TICK_CYCLES - 1));
    next_s.tickCnt = tick ? 32'h0000_0000 : 32'(s.tickCnt + 32'h0000_0001);
    // flow direction from measured current
    dsgNow = meas.current[15] && (magI > s.cfg.dsgThr); // R15
    chgNow = !meas.current[15] && (magI > s.cfg.chgThr); // R16
    quiet = magAvg < s.cfg.quitI;
    loud = magAvg > s.cfg.quitI;
    if (dsgNow) next_s.lastChg = 1'b0;
    if (chgNow) next_s.lastChg = 1'b1;
    // rest detection, evaluated once per second
    if (tick) begin
      case (s.relax)
        glm_pkg::GLM_ACTIVE: begin
          // a single dwell time chosen by the last flow direction
          next_s.dwell = quiet ? incSat(s.dwell) : 16'h0000;
          if (quiet && incSat(s.dwell) >= dwellLim) begin
            next_s.relax = glm_pkg::GLM_RELAX; // R17
            next_s.dwell = 16'h0000;
            next_s.relaxSecs = 16'h0000;
            closeCycle = 1'b1;
          end
        end
        glm_pkg::GLM_RELAX: begin
          next_s.relaxSecs = incSat(s.relaxSecs); // R18
          next_s.dwell = loud ? incSat(s.dwell) : 16'h0000;
          if (loud && incSat(s.dwell) >= s.cfg.quitRlx) begin
            next_s.relax = glm_pkg::GLM_ACTIVE; // R20
            next_s.dwell = 16'h0000;
          end
        end
        default: begin
          next_s.relax = glm_pkg::GLM_ACTIVE;
          next_s.dwell = 16'h0000;
        end
      endcase
      // discharge cycle accumulation for present and last-run averages
      if (chgNow) closeCycle = 1'b1;
      if (dsgNow && !closeCycle) begin
        if (!s.inCycle) begin
          next_s.inCycle = 1'b1;
          next_s.sumI = {16'h0000, magI}; // R2
          next_s.sumP = {16'h0000, instP}; // R7
          next_s.cnt = 16'h0001;
        end else if (s.cnt != 16'hFFFF) begin
          // stops growing at full count; average then freezes
          next_s.sumI = s.sumI + {16'h0000, magI};
          next_s.sumP = s.sumP + {16'h0000, instP};
          next_s.cnt = 16'(s.cnt + 16'h0001);
        end
      end
      if (closeCycle && s.inCycle) begin
        next_s.inCycle = 1'b0;
        next_s.lastI = presI; // R1
        next_s.lastP = presP; // R6
      end
      // first-order filter; integer step leaves a small dead band
      diff = 17'(meas.avgCurrent) - 17'(s.filt);
      next_s.filt = 16'(17'(s.filt) + diff / TauDiv); // R3
    end
    // load model selection
    if (!s.cfg.mode) begin
      case (s.cfg.sel)
        glm_pkg::SEL_LAST: model = s.lastI; // R1
        glm_pkg::SEL_PRESENT: model = presI; // R2
        glm_pkg::SEL_AVG: model = magAvg; // R3
        glm_pkg::SEL_FILT: model = magFilt; // R3
        glm_pkg::SEL_DESIGN: model = 16'(s.cfg.dcap / glm_pkg::RATE_DIV); // R4
        glm_pkg::SEL_HOST: model = s.cfg.hostRate; // R5
        glm_pkg::SEL_USER: model = s.cfg.userI; // R5
        default: model = presI; // R23
      endcase
    end else begin
      case (s.cfg.sel)
        glm_pkg::SEL_LAST: model = s.lastP; // R6
        glm_pkg::SEL_PRESENT: model = presP; // R7
        glm_pkg::SEL_AVG: model = power(magAvg, meas.voltage, s.cfg.escale); // R8
        glm_pkg::SEL_FILT: model = power(magFilt, meas.voltage, s.cfg.escale); // R8
        glm_pkg::SEL_DESIGN: model = 16'(s.cfg.denergy / glm_pkg::RATE_DIV); // R9
        glm_pkg::SEL_HOST: model = s.cfg.hostRate; // R10
        glm_pkg::SEL_USER: model = s.cfg.userP; // R10
        default: model = s.lastP; // R23
      endcase
    end
    // registered outputs
    next_s.out.loadModel = model;
    next_s.out.loadModeStatus = s.cfg.mode; // R22
    next_s.out.resCompLoaded = s.cfg.reserve_comp_select; // R12
    next_s.out.compRate = s.cfg.reserve_comp_select ? model : 16'h0000; // R12
    next_s.out.resChg = s.cfg.resChg; // R11
    next_s.out.resEn = s.cfg.resEn; // R11
    next_s.out.resChgInUse = (remainingCharge == 16'h0000); // R11
    next_s.out.resEnInUse = (remainingEnergy == 16'h0000); // R11
    next_s.out.relaxActive = (s.relax == glm_pkg::GLM_RELAX);
    next_s.out.ocvEnable = (s.relax == glm_pkg::GLM_RELAX) &&
                           (s.relaxSecs >= glm_pkg::OCV_WAIT_S); // R18
    next_s.out.qmaxUpdateEnable = (s.relax == glm_pkg::GLM_RELAX) &&
                                  (s.relaxSecs >= glm_pkg::OCV_WAIT_S) &&
                                  (meas.dvdt < glm_pkg::DVDT_MAX_UVS); // R19
    next_s.out.dischargeFlow = dsgNow;
    next_s.out.chargeFlow = chgNow;
    // capacity learning only while the update window is open
    if (s.out.qmaxUpdateEnable && meas.qmaxValid) next_s.qmax = meas.qmaxSample; // R21
    // register writes; a software seed overrides a same-cycle update
    if (regWrite) begin
      case (regAddr)
        glm_pkg::REG_CTRL: begin
          next_s.cfg.mode = regWdata[glm_pkg::CTRL_MODE_BIT];
          next_s.cfg.sel = regWdata[glm_pkg::CTRL_SEL_LSB +: 3];
          next_s.cfg.reserve_comp_select = regWdata[glm_pkg::CTRL_RESERVE_COMP_SELECT_BIT];
        end
        glm_pkg::REG_ESCALE: begin
          // other scale values are ignored, keeping units coherent
          if (regWdata == glm_pkg::ESCALE_ONE || regWdata == glm_pkg::ESCALE_TEN)
            next_s.cfg.escale = regWdata; // R14
        end
        glm_pkg::REG_DCAP: next_s.cfg.dcap = regWdata;
        glm_pkg::REG_DENERGY: next_s.cfg.denergy = regWdata;
        glm_pkg::REG_HRATE: next_s.cfg.hostRate = regWdata;
        glm_pkg::REG_URATE_I: next_s.cfg.userI = regWdata;
        glm_pkg::REG_URATE_P: next_s.cfg.userP = regWdata;
        glm_pkg::REG_DSG_THR: next_s.cfg.dsgThr = regWdata;
        glm_pkg::REG_CHG_THR: next_s.cfg.chgThr = regWdata;
        glm_pkg::REG_QUIT_I: next_s.cfg.quitI = regWdata;
        glm_pkg::REG_DSG_RLX: next_s.cfg.dsgRlx = regWdata;
        glm_pkg::REG_CHG_RLX: next_s.cfg.chgRlx = regWdata;
        glm_pkg::REG_QUIT_RLX: next_s.cfg.quitRlx = regWdata;
        glm_pkg::REG_QMAX: next_s.qmax = regWdata; // R21
        glm_pkg::REG_RES_CHG: next_s.cfg.resChg = regWdata;
        glm_pkg::REG_RES_EN: next_s.cfg.resEn = regWdata;
        default: ; // read-only or unmapped: dropped
      endcase
    end
    // register reads, data valid the next cycle only
    if (regRead) begin
      case (regAddr)
        glm_pkg::REG_CTRL: next_s.rdata = {7'h00, s.cfg.reserve_comp_select, 1'b0, s.cfg.sel,
                                           3'h0, s.cfg.mode};
        glm_pkg::REG_ESCALE: next_s.rdata = s.cfg.escale;
        glm_pkg::REG_DCAP: next_s.rdata = s.cfg.dcap;
        glm_pkg::REG_DENERGY: next_s.rdata = s.cfg.denergy;
        glm_pkg::REG_HRATE: next_s.rdata = s.cfg.hostRate;
        glm_pkg::REG_URATE_I: next_s.rdata = s.cfg.userI;
        glm_pkg::REG_URATE_P: next_s.rdata = s.cfg.userP;
        glm_pkg::REG_DSG_THR: next_s.rdata = s.cfg.dsgThr;
        glm_pkg::REG_CHG_THR: next_s.rdata = s.cfg.chgThr;
        glm_pkg::REG_QUIT_I: next_s.rdata = s.cfg.quitI;
        glm_pkg::REG_DSG_RLX: next_s.rdata = s.cfg.dsgRlx;
        glm_pkg::REG_CHG_RLX: next_s.rdata = s.cfg.chgRlx;
        glm_pkg::REG_QUIT_RLX: next_s.rdata = s.cfg.quitRlx;
        glm_pkg::REG_QMAX: next_s.rdata = s.qmax;
        glm_pkg::REG_RES_CHG: next_s.rdata = s.cfg.resChg;
        glm_pkg::REG_RES_EN: next_s.rdata = s.cfg.resEn;
        glm_pkg::REG_STATUS: next_s.rdata = {9'h000, s.out.chargeFlow,
                                             s.out.dischargeFlow, s.out.qmaxUpdateEnable,
                                             s.out.ocvEnable, s.out.relaxActive,
                                             s.inCycle, s.out.loadModeStatus}; // R22
        glm_pkg::REG_MODEL: next_s.rdata = s.out.loadModel;
        glm_pkg::REG_LAST_I: next_s.rdata = s.lastI;
        glm_pkg::REG_LAST_P: next_s.rdata = s.lastP;
        glm_pkg::REG_FILT_I: next_s.rdata = s.filt;
        default: next_s.rdata = 16'h0000; // unmapped reads zero
      endcase
    end
    // synchronous reset to documented defaults
    if (rst) begin
      next_s = '0;
      next_s.cfg.sel = glm_pkg::SEL_RST;
      next_s.cfg.escale = glm_pkg::ESCALE_ONE;
      next_s.cfg.dsgThr = glm_pkg::THR_RST;
      next_s.cfg.chgThr = glm_pkg::THR_RST;
      next_s.cfg.quitI = glm_pkg::QUIT_I_RST;
      next_s.cfg.dsgRlx = glm_pkg::RLX_RST;
      next_s.cfg.chgRlx = glm_pkg::RLX_RST;
      next_s.cfg.quitRlx = glm_pkg::QUIT_RLX_RST;
      next_s.relax = glm_pkg::GLM_ACTIVE;
    end
  end
  // ---------------------------------------------
  // register stage
  // ---------------------------------------------
  always_ff @(posedge clk) begin
    s <= next_s;
  end
  assign regRdata = s.rdata;
  assign status = s.out;
  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_mode_mirror;
    regWrite && regAddr == glm_pkg::REG_CTRL |-> ##2
      status.loadModeStatus == $past(regWdata[0], 2);
  endproperty
  a_mode_mirror: assert property (p_mode_mirror) else $error("mode bit not mirrored"); // R22
  property p_cc_design;
    !s.cfg.mode && s.cfg.sel == glm_pkg::SEL_DESIGN |=>
      status.loadModel == 16'($past(s.cfg.dcap) / glm_pkg::RATE_DIV);
  endproperty
  a_cc_design: assert property (p_cc_design) else $error("capacity rate wrong"); // R4
  property p_cp_design;
    s.cfg.mode && s.cfg.sel == glm_pkg::SEL_DESIGN |=>
      status.loadModel == 16'($past(s.cfg.denergy) / glm_pkg::RATE_DIV);
  endproperty
  a_cp_design: assert property (p_cp_design) else $error("energy rate wrong"); // R9
  property p_cc_host;
    !s.cfg.mode && s.cfg.sel == glm_pkg::SEL_HOST |=> status.loadModel == $past(s.cfg.hostRate);
  endproperty
  a_cc_host: assert property (p_cc_host) else $error("host rate not used"); // R5
  property p_cp_user;
    s.cfg.mode && s.cfg.sel == glm_pkg::SEL_USER |=> status.loadModel == $past(s.cfg.userP);
  endproperty
  a_cp_user: assert property (p_cp_user) else $error("user power rate not used"); // R10
  property p_cp_undef;
    s.cfg.mode && s.cfg.sel == 3'h7 |=> status.loadModel == $past(s.lastP);
  endproperty
  a_cp_undef: assert property (p_cp_undef) else $error("undefined selector not default"); // R23
  property p_ocv_wait;
    status.ocvEnable |-> $past(s.relaxSecs) >= glm_pkg::OCV_WAIT_S && status.relaxActive;
  endproperty
  a_ocv_wait: assert property (p_ocv_wait) else $error("voltage reading before wait"); // R18
  property p_qmax_dvdt;
    status.qmaxUpdateEnable |-> $past(meas.dvdt) < glm_pkg::DVDT_MAX_UVS && status.ocvEnable;
  endproperty
  a_qmax_dvdt: assert property (p_qmax_dvdt) else $error("update with voltage moving"); // R19
  property p_exit_loud;
    s.relax == glm_pkg::GLM_RELAX ##1 s.relax == glm_pkg::GLM_ACTIVE |->
      $past(magnitude(meas.avgCurrent)) > $past(s.cfg.quitI);
  endproperty
  a_exit_loud: assert property (p_exit_loud) else $error("rest left while quiet"); // R20
  property p_scale_legal;
    s.cfg.escale == glm_pkg::ESCALE_ONE || s.cfg.escale == glm_pkg::ESCALE_TEN;
  endproperty
  a_scale_legal: assert property (p_scale_legal) else $error("illegal energy scale"); // R14
  property p_qmax_seed;
    regWrite && regAddr == glm_pkg::REG_QMAX |=> s.qmax == $past(regWdata);
  endproperty
  a_qmax_seed: assert property (p_qmax_seed) else $error("capacity seed lost"); // R21
  property p_dsg_flow;
    meas.current[15] && magnitude(meas.current) > s.cfg.dsgThr |=> status.dischargeFlow;
  endproperty
  a_dsg_flow: assert property (p_dsg_flow) else $error("discharge flow missed"); // R15
  c_enter_rest: cover property ($rose(status.relaxActive));
  c_ocv_open: cover property ($rose(status.ocvEnable));
  c_qmax_learn: cover property (s.out.qmaxUpdateEnable && meas.qmaxValid);
  c_last_run: cover property ($fell(s.inCycle));
endmodule : glm_load_relax

//--- logic/glm_pkg.sv
// Purpose: shared constants and carriers for the load model and relax detector
// Assumes: 100 MHz clk, 16-bit plain register port, word-indexed registers
// Notes: current is signed mA, negative while discharging
package glm_pkg;
  // ---------------------------------------------
  // register port and map
  // ---------------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam logic [4:0] REG_CTRL = 5'h00; // mode, selector, reserve select
  localparam logic [4:0] REG_ESCALE = 5'h01; // energy scale, 1 or 10
  localparam logic [4:0] REG_DCAP = 5'h02; // design capacity, mAh
  localparam logic [4:0] REG_DENERGY = 5'h03; // design energy
  localparam logic [4:0] REG_HRATE = 5'h04; // host rate value
  localparam logic [4:0] REG_URATE_I = 5'h05; // user current rate
  localparam logic [4:0] REG_URATE_P = 5'h06; // user power rate
  localparam logic [4:0] REG_DSG_THR = 5'h07; // discharge threshold, mA
  localparam logic [4:0] REG_CHG_THR = 5'h08; // charge threshold, mA
  localparam logic [4:0] REG_QUIT_I = 5'h09; // quit current, mA
  localparam logic [4:0] REG_DSG_RLX = 5'h0A; // discharge relax time, s
  localparam logic [4:0] REG_CHG_RLX = 5'h0B; // charge relax time, s
  localparam logic [4:0] REG_QUIT_RLX = 5'h0C; // quit relax time, s
  localparam logic [4:0] REG_QMAX = 5'h0D; // max chemical capacity
  localparam logic [4:0] REG_RES_CHG = 5'h0E; // reserve charge
  localparam logic [4:0] REG_RES_EN = 5'h0F; // reserve energy
  localparam logic [4:0] REG_STATUS = 5'h10; // read only flags
  localparam logic [4:0] REG_MODEL = 5'h11; // read only load model
  localparam logic [4:0] REG_LAST_I = 5'h12; // read only last-run current
  localparam logic [4:0] REG_LAST_P = 5'h13; // read only last-run power
  localparam logic [4:0] REG_FILT_I = 5'h14; // read only filtered current
  // ---------------------------------------------
  // fields and reset values
  // ---------------------------------------------
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_SEL_LSB = 4;
  localparam int CTRL_RESERVE_COMP_SELECT_BIT = 8;
  localparam logic [2:0] SEL_LAST = 3'h0;
  localparam logic [2:0] SEL_PRESENT = 3'h1;
  localparam logic [2:0] SEL_AVG = 3'h2;
  localparam logic [2:0] SEL_FILT = 3'h3;
  localparam logic [2:0] SEL_DESIGN = 3'h4;
  localparam logic [2:0] SEL_HOST = 3'h5;
  localparam logic [2:0] SEL_USER = 3'h6;
  localparam logic [2:0] SEL_RST = 3'h1; // default of current mode
  localparam logic [15:0] ESCALE_ONE = 16'h0001;
  localparam logic [15:0] ESCALE_TEN = 16'h000A;
  localparam logic [15:0] THR_RST = 16'h0064; // plain default
  localparam logic [15:0] QUIT_I_RST = 16'h0028; // plain default
  localparam logic [15:0] RLX_RST = 16'h003C; // plain default
  localparam logic [15:0] QUIT_RLX_RST = 16'h0001; // plain default
  // ---------------------------------------------
  // timing and arithmetic
  // ---------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_TIME_NS = 1_000_000_000; // one second
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int OCV_WAIT_MIN = 6;
  localparam logic [15:0] OCV_WAIT_S = 16'(OCV_WAIT_MIN * 60);
  localparam int LPF_TAU_S = 14;
  localparam logic [15:0] DVDT_MAX_UVS = 16'h0004;
  localparam logic [15:0] RATE_DIV = 16'h0005;
  localparam logic [31:0] PWR_DIV_MILLI = 32'h0000_03E8;
  localparam logic [31:0] PWR_DIV_CENTI = 32'h0000_2710;
  // ---------------------------------------------
  // types
  // ---------------------------------------------
  typedef enum logic {GLM_ACTIVE, GLM_RELAX} glm_relax_t;
  typedef struct packed {
    logic mode;
    logic [2:0] sel;
    logic reserve_comp_select;
    logic [15:0] escale, dcap, denergy, hostRate, userI, userP;
    logic [15:0] dsgThr, chgThr, quitI, dsgRlx, chgRlx, quitRlx;
    logic [15:0] resChg, resEn;
  } glm_cfg_t;
  typedef struct packed {
    logic signed [15:0] current;
    logic signed [15:0] avgCurrent;
    logic [15:0] voltage; // mV
    logic [15:0] dvdt; // uV/s
    logic [15:0] qmaxSample;
    logic qmaxValid;
  } glm_meas_t;
  typedef struct packed {
    logic [15:0] loadModel, compRate, resChg, resEn;
    logic loadModeStatus, resCompLoaded, relaxActive, ocvEnable;
    logic qmaxUpdateEnable, dischargeFlow, chargeFlow;
    logic resChgInUse, resEnInUse;
  } glm_out_t;
endpackage : glm_pkg
